/* File: hdl/iibd_top.sv */
// host bus decode, input read back and change-of-state interrupt
//
// How it works
// - eight byte block decoded, unused answer fixed
// - base compared on address bits 3..9 only
// - low three address bits pick the register
// - fitted jumper wants 0, removed wants 1
// - filter selects map reversed within each byte
// - interrupt only on jumper chosen line
// - any input edge interrupts while enabled
// - read +2 enables, write +2 disables
// - write +1 clears the pending interrupt
// - +1 reads inputs 0..7, +5 reads 8..15
// - energized input reads 0, idle reads 1
module iibd_top
  import iibd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   rdHit,
  input  wire logic [BASE_W-1:0] baseJumper,
  input  wire logic [NUM_IN-1:0] inputBit,
  input  wire logic [NUM_IN-1:0] filterSelect,
  output logic      [NUM_IN-1:0] slowFilterEn,
  input  wire logic [IRQ_W-1:0]  interruptLevelSelect,
  output logic      [IRQ_W-1:0]  irqLine,
  output logic                   irq
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rstMeta;
  logic rstnSync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta  <= 1'b0;
      rstnSync <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstnSync <= rstMeta;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // installed jumper means the address bit must be low
  function automatic logic baseMatch(input logic [ADDR_W-1:0] a,
                                     input logic [BASE_W-1:0] j);
    baseMatch = (a[BASE_MSB:BASE_LSB] == ~j);
  endfunction : baseMatch

  function automatic logic [DATA_W-1:0] readLevels(input logic [BYTE_W-1:0] s);
    readLevels = ~s;
  endfunction : readLevels

  // ****************************************************************
  // decode
  // ****************************************************************
  logic             hit;
  logic [OFS_W-1:0] ofs;
  logic             rdAcc;
  logic             wrAcc;

  assign hit   = baseMatch(addr, baseJumper);
  assign ofs   = addr[OFS_MSB:0];
  assign rdAcc = rd && hit;
  assign wrAcc = wr && hit;

  // ****************************************************************
  // input synchronising and edge detect
  // ****************************************************************
  logic [NUM_IN-1:0] syncIn;
  logic [NUM_IN-1:0] prevIn;
  logic [NUM_IN-1:0] next_prevIn;
  logic              anyChange;

  iibd_sync #(
    .W (NUM_IN)
  ) u_sync (
    .clk  (clk),
    .rstn (rstnSync),
    .din  (inputBit),
    .dout (syncIn)
  );

  always_comb begin
    next_prevIn = syncIn;
    anyChange   = |(syncIn ^ prevIn);
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      prevIn <= '0;
    end else begin
      prevIn <= next_prevIn;
    end
  end

  // ****************************************************************
  // change-of-state control and interrupt state
  // ****************************************************************
  iibd_chg_t         chgState;
  iibd_chg_t         next_chgState;
  logic              pending;
  logic              next_pending;
  logic [DATA_W-1:0] intEnable;
  logic [DATA_W-1:0] next_intEnable;
  logic              clearReq;
  logic              setReq;

  always_comb begin
    next_chgState  = chgState;
    next_intEnable = intEnable;
    // read +2 arms, write +2 disarms
    unique case (chgState)
      CHG_OFF: begin
        if (rdAcc && ofs == OFS_CHG_CTL) begin
          next_chgState = CHG_ARMED;
        end
      end
      CHG_ARMED: begin
        if (wrAcc && ofs == OFS_CHG_CTL) begin
          next_chgState = CHG_OFF;
        end
      end
    endcase
    if (wrAcc && ofs == OFS_INT_EN) begin
      next_intEnable = wdata & STATUS_MASK;
    end
    // clear by write at +1, or write one at status
    clearReq = wrAcc && ((ofs == OFS_IN_LOW) ||
               (ofs == OFS_STATUS && wdata[STAT_CHG_BIT]));
    setReq   = anyChange && (chgState == CHG_ARMED);
    // latched; a new edge beats a clear in the same cycle
    next_pending = setReq || (pending && !clearReq);
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      chgState  <= CHG_OFF;
      pending   <= 1'b0;
      intEnable <= INT_EN_RESET;
    end else begin
      chgState  <= next_chgState;
      pending   <= next_pending;
      intEnable <= next_intEnable;
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  // disarming also silences a bit already latched
  assign irq = pending && intEnable[STAT_CHG_BIT] && (chgState == CHG_ARMED);
  // only the fitted level jumper, no jumper means no line
  assign irqLine = {IRQ_W{irq}} & interruptLevelSelect & LEGAL_IRQ;

  // ****************************************************************
  // filter jumper routing
  // ****************************************************************
  // reversed mapping inside each byte
  always_comb begin
    for (int n = 0; n < BYTE_W; n++) begin
      slowFilterEn[BYTE_W-1-n]          = filterSelect[n];
      slowFilterEn[NUM_IN-1-n]          = filterSelect[BYTE_W+n];
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [DATA_W-1:0] next_rdata;
  logic              next_rdHit;

  always_comb begin
    next_rdata = ZERO_BYTE;
    next_rdHit = rdAcc;
    if (rdAcc) begin
      // unused slots answer a fixed byte
      unique case (ofs)
        OFS_IN_LOW:  next_rdata = readLevels(syncIn[BYTE_W-1:0]);
        OFS_IN_HIGH: next_rdata = readLevels(syncIn[NUM_IN-1:BYTE_W]);
        OFS_STATUS:  next_rdata = {{(DATA_W-1){1'b0}}, pending};
        OFS_INT_EN:  next_rdata = intEnable;
        default:     next_rdata = UNUSED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      rdata <= ZERO_BYTE;
      rdHit <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdHit <= next_rdHit;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstnSync);

  sequence rdLowS;
    rd && hit && ofs == OFS_IN_LOW;
  endsequence

  sequence rdHighS;
    rd && hit && ofs == OFS_IN_HIGH;
  endsequence

  sequence armS;
    rd && hit && ofs == OFS_CHG_CTL;
  endsequence

  sequence disarmS;
    wr && hit && ofs == OFS_CHG_CTL;
  endsequence

  sequence edgeArmedS;
    chgState == CHG_ARMED && (syncIn != prevIn);
  endsequence

  block_miss_a: assert property (rd && !hit |=> !rdHit && rdata == ZERO_BYTE)
    else $error("read outside block was answered");

  decode_hit_a: assert property (rd && addr[BASE_MSB:BASE_LSB] == ~baseJumper |=> rdHit)
    else $error("matching read not answered");

  read_low_a: assert property (rdLowS |=> rdata == ~$past(syncIn[BYTE_W-1:0]))
    else $error("low input byte wrong");

  read_high_a: assert property (rdHighS |=> rdata == ~$past(syncIn[NUM_IN-1:BYTE_W]))
    else $error("high input byte wrong");

  chg_arm_a: assert property (armS ##1 (!disarmS)[*2] |=> chgState == CHG_ARMED)
    else $error("read at +2 did not arm");

  // irq must drop with the state, a re-arm one cycle on is legal
  chg_disarm_a: assert property (disarmS |=> chgState == CHG_OFF && !irq)
    else $error("write at +2 did not disarm");

  // edge while armed latches within one cycle
  edge_latch_a: assert property (edgeArmedS |=> pending)
    else $error("change of state not latched");

  // clear drops the bit when no new edge
  pend_clear_a: assert property (wr && hit && ofs == OFS_IN_LOW &&
                                 !(chgState == CHG_ARMED && syncIn != prevIn) |=> !pending)
    else $error("clear at +1 left interrupt pending");

  pend_hold_a: assert property (pending && !(wr && hit) |=> pending)
    else $error("pending dropped without clear");

  // only the selected legal line moves
  irq_line_a: assert property (irq |-> irqLine == (interruptLevelSelect & LEGAL_IRQ))
    else $error("interrupt on wrong line");

  filter_map_a: assert property (slowFilterEn[BYTE_W-1] == filterSelect[0] &&
                                 slowFilterEn[BYTE_W] == filterSelect[NUM_IN-1])
    else $error("filter select misrouted");

endmodule : iibd_top

/* File: pkg/iibd_pkg.sv */
// shared constants for the isolated input bus decode block
package iibd_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int NUM_IN   = 16;
  localparam int BASE_W   = 7;
  localparam int OFS_W    = 3;
  localparam int IRQ_W    = 16;
  localparam int BYTE_W   = 8;

  // ****************************************************************
  // address fields
  // ****************************************************************
  localparam int BASE_LSB = 3;
  localparam int BASE_MSB = 9;
  localparam int OFS_MSB  = 2;

  // ****************************************************************
  // offsets inside the eight byte block
  // ****************************************************************
  localparam logic [OFS_W-1:0] OFS_IN_LOW  = 3'h1;
  localparam logic [OFS_W-1:0] OFS_CHG_CTL = 3'h2;
  localparam logic [OFS_W-1:0] OFS_STATUS  = 3'h3;
  localparam logic [OFS_W-1:0] OFS_INT_EN  = 3'h4;
  localparam logic [OFS_W-1:0] OFS_IN_HIGH = 3'h5;

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int STAT_CHG_BIT = 0;
  localparam logic [DATA_W-1:0] UNUSED_READ  = 8'hFF;
  localparam logic [DATA_W-1:0] STATUS_MASK  = 8'h01;
  localparam logic [DATA_W-1:0] INT_EN_RESET = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
  // host interrupt lines that a level jumper may select
  localparam logic [IRQ_W-1:0]  LEGAL_IRQ    = 16'hDCFC;

  typedef enum logic {CHG_OFF, CHG_ARMED} iibd_chg_t;

endpackage : iibd_pkg

/* File: hdl/iibd_sync.sv */
// two flip-flop synchroniser for a vector of levels
module iibd_sync
  import iibd_pkg::*;
#(
  parameter int W = NUM_IN
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  // ****************************************************************
  // capture
  // ****************************************************************
  // stage1 feeds stage2 only, nothing else looks at it
  always_comb begin
    next_stage1 = din;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign dout = stage2;

endmodule : iibd_sync

/* File: verification/iibd_host_model.sv */
// host cpu model driving the card's byte wide io bus
module iibd_host_model
  import iibd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rdHit,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr  = 10'h000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // caller keeps base in 100..3FF
  // idle bus shows inverted values, not the last ones
  task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : busWrite

  task automatic busRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                         output logic h);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
    h = rdHit;
  endtask : busRead
endmodule : iibd_host_model

/* File: verification/iibd_top_tb_top.sv */
// self-checking bench for the isolated input bus decode block
module iibd_top_tb_top import iibd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [OFS_W-1:0]  ofs;
    logic [DATA_W-1:0] exp;
  } iibd_row_t;

  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              rdHit;
  logic [BASE_W-1:0] baseJumper;
  logic [NUM_IN-1:0] inputBit;
  logic [NUM_IN-1:0] filterSelect;
  logic [NUM_IN-1:0] slowFilterEn;
  logic [IRQ_W-1:0]  interruptLevelSelect;
  logic [IRQ_W-1:0]  irqLine;
  logic              irq;
  logic [ADDR_W-1:0] base;
  int                badCount = 0;
  int                nChecks = 0;

  // inputs held at A53C: energized bits read back as 0
  localparam iibd_row_t ROWS [8] = '{
    '{3'h1, 8'hC3}, '{3'h5, 8'h5A}, '{3'h0, 8'hFF}, '{3'h3, 8'h00},
    '{3'h4, 8'h01}, '{3'h6, 8'hFF}, '{3'h7, 8'hFF}, '{3'h2, 8'hFF}};

  iibd_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rdHit(rdHit), .baseJumper(baseJumper), .inputBit(inputBit),
    .filterSelect(filterSelect), .slowFilterEn(slowFilterEn),
    .interruptLevelSelect(interruptLevelSelect), .irqLine(irqLine), .irq(irq));

  iibd_host_model host (.clk(clk), .rdata(rdata), .rdHit(rdHit), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finishTest;
    if (badCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finishTest

  task automatic rdAt(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                      input logic hit);
    logic [DATA_W-1:0] d;
    logic              h;
    host.busRead(a, d, h);
    check(16'(d), 16'(exp));
    check(16'(h), 16'(hit));
  endtask : rdAt

  task automatic flip(input int n);
    @(posedge clk);
    inputBit[n] <= ~inputBit[n];
  endtask : flip

  // bounded wait; a miss ends the run
  task automatic waitIrq(input logic lvl);
    // step off the launching edge before the first look
    @(negedge clk);
    for (int i = 0; i < 10 && irq !== lvl; i++) begin
      @(negedge clk);
    end
    check(16'(irq), 16'(lvl));
    if (irq !== lvl) finishTest();
  endtask : waitIrq

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    base = 10'h300;
    baseJumper = ~base[BASE_MSB:BASE_LSB];
    inputBit = 16'hA53C;
    filterSelect = 16'h0000;
    interruptLevelSelect = 16'h0020;
    repeat (2) @(posedge clk);
    check(16'(rdHit), 16'h0000);
    check(irqLine, 16'h0000);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ROWS[i]) rdAt(base + ADDR_W'(ROWS[i].ofs), ROWS[i].exp, 1'b1);
    // host fits filters; one jumper at a time
    for (int n = 0; n < NUM_IN; n++) begin
      @(posedge clk);
      filterSelect <= 16'h0001 << n;
      @(negedge clk);
      check(slowFilterEn, 16'h0001 << (n < 8 ? 7 - n : 23 - n));
    end
    @(posedge clk);
    base = 10'h1A8;
    baseJumper <= ~base[BASE_MSB:BASE_LSB];
    rdAt(10'h301, 8'h00, 1'b0);
    rdAt(10'h1A1, 8'h00, 1'b0);
    rdAt(10'h3A9, 8'h00, 1'b0);
    rdAt(base + 10'h005, 8'h5A, 1'b1);
    // clear while already armed by the row read at +2, then read +2 again
    host.busWrite(base + 10'h001, 8'h00);
    rdAt(base + 10'h002, 8'hFF, 1'b1);
    flip(0);
    waitIrq(1'b1);
    check(irqLine, 16'h0020);
    host.busWrite(10'h301, 8'h00);
    rdAt(base + 10'h003, 8'h01, 1'b1);
    check(16'(irq), 16'h0001);
    host.busWrite(base + 10'h001, 8'h00);
    waitIrq(1'b0);
    // falling edge while masked by enable
    host.busWrite(base + 10'h004, 8'h00);
    flip(0);
    repeat (6) @(negedge clk);
    check(16'(irq), 16'h0000);
    rdAt(base + 10'h003, 8'h01, 1'b1);
    host.busWrite(base + 10'h004, 8'h01);
    waitIrq(1'b1);
    host.busWrite(base + 10'h003, 8'h01);
    waitIrq(1'b0);
    // edges while disarmed are lost
    host.busWrite(base + 10'h002, 8'h00);
    flip(15);
    repeat (6) @(negedge clk);
    check(16'(irq), 16'h0000);
    rdAt(base + 10'h003, 8'h00, 1'b1);
    rdAt(base + 10'h002, 8'hFF, 1'b1);
    flip(8);
    waitIrq(1'b1);
    @(posedge clk);
    interruptLevelSelect <= 16'h0001;
    @(negedge clk);
    check(irqLine, 16'h0000);
    @(posedge clk);
    interruptLevelSelect <= 16'h0000;
    @(negedge clk);
    check(irqLine, 16'h0000);
    @(posedge clk);
    interruptLevelSelect <= 16'h8004;
    @(negedge clk);
    check(irqLine, 16'h8004);
    // second reset in mid-run drops a live interrupt
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check(16'(irq), 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdAt(base + 10'h003, 8'h00, 1'b1);
    rdAt(base + 10'h004, 8'h01, 1'b1);
    finishTest();
  end
endmodule : iibd_top_tb_top
